// ### kbc_pm_mailbox_map.vh
`ifndef KBC_PM_MAILBOX_MAP_VH
`define KBC_PM_MAILBOX_MAP_VH

// Firmware-side register selectors (offsets of this block's own choosing)
`define REG_IRQ_LINE_CONTROL 3'h0
`define REG_KBC_CHANNEL_STATUS 3'h1
`define REG_KEYBOARD_DATA_OUT 3'h2
`define REG_MOUSE_DATA_OUT 3'h3
`define REG_KBC_DATA_IN 3'h4
`define REG_PM_CHANNEL_STATUS 3'h5
`define REG_PM_DATA_OUT 3'h6
`define REG_PM_DATA_IN 3'h7
`define REG_HOST_IFACE_CONTROL_SEL 1'b1

// Host I/O addresses
`define HOST_KBC_DATA 8'h60
`define HOST_KBC_CMD 8'h64
`define HOST_PM_DATA 8'h62
`define HOST_PM_CMD 8'h66

// Reset values
`define IRQ_LINE_CONTROL_RESET 8'h07
`define STATUS_RESET 8'h00
`define HOST_IFACE_CONTROL_RESET 8'h00

// Status byte fields
`define ST_OUTBUF_FULL 0
`define ST_INBUF_FULL 1
`define ST_GP_FLAG_ZERO 2
`define ST_LAST_CMD_ADDR 3
`define ST_FW_WRITE_MASK 8'hf4

// Interrupt-line control fields
`define IRQC_KBD_DIRECT 0
`define IRQC_MOUSE_DIRECT 1
`define IRQC_PM_DIRECT 2
`define IRQC_PULSE_LO 3
`define IRQC_PULSE_HI 5
`define IRQC_INVERT 6
`define IRQC_PUSH_PULL 7

// Host interface control fields
`define HIC_KBD_HOST_IRQ_EN 0
`define HIC_MOUSE_HOST_IRQ_EN 1
`define HIC_KBC_CORE_EMPTY_EN 2
`define HIC_KBC_CORE_FULL_EN 3
`define HIC_PM_HOST_IRQ_EN 4
`define HIC_PM_CORE_EMPTY_EN 5
`define HIC_PM_CORE_FULL_EN 6

// Pulse lengths, in clock cycles
`define PULSE_CYCLES_1 5'd1
`define PULSE_CYCLES_2 5'd2
`define PULSE_CYCLES_4 5'd4
`define PULSE_CYCLES_8 5'd8
`define PULSE_MAX_CYCLES 5'd16

`endif

// ### kbc_pm_host_mailbox.v
`timescale 1ns/1ps
`include "kbc_pm_mailbox_map.vh"

module kbc_pm_host_mailbox
(
    input wire clk,
    input wire nrst,
    input wire clk_en,
    // Host I/O side
    input wire host_sel,
    input wire host_wr,
    input wire host_rd,
    input wire [7:0] host_addr,
    input wire [7:0] host_wdata,
    output reg [7:0] host_rdata,
    // Firmware side
    input wire fw_sel,
    input wire fw_wr,
    input wire fw_rd,
    input wire fw_ctl_sel,
    input wire [2:0] fw_addr,
    input wire [7:0] fw_wdata,
    output reg [7:0] fw_rdata,
    // Host-bound byte stream through the two-entry buffer
    output wire fw_out_ready,
    // Host interrupt lines: drive value and enables (enable low = driving)
    input wire [2:0] irq_pin_in,
    output reg [2:0] irq_out,
    output reg [2:0] irq_oe_n,
    // Core interrupts
    output wire kbc_core_empty_irq,
    output wire kbc_core_full_irq,
    output wire pm_core_empty_irq,
    output wire pm_core_full_irq
);

    reg [7:0] irq_line_control;
    reg [7:0] host_iface_control;
    reg [7:0] kbc_channel_status;
    reg [7:0] pm_channel_status;
    reg [7:0] kbc_in_buffer;
    reg [7:0] pm_in_buffer;
    reg [7:0] kbc_out_buffer;
    reg [7:0] pm_out_buffer;
    reg [2:0] pin_s1;
    reg [2:0] pin_s2;
    reg [2:0] pin_s3;
    reg [2:0] pin_level;
    reg [2:0] pulse_active;
    reg [4:0] pulse_cnt0;
    reg [4:0] pulse_cnt1;
    reg [4:0] pulse_cnt2;
    reg [2:0] hw_line;
    reg [2:0] line_value;
    // Which source last filled the shared keyboard buffer, for level mode
    reg fifo_last_mouse;
    integer i;
    integer j;

    // Two-entry skid buffer between firmware data-out writes and the output buffers
    reg [9:0] fifo_data [0:1];
    reg fifo_rd_ptr;
    reg fifo_wr_ptr;
    reg [1:0] fifo_count;

    wire [2:0] mode = irq_line_control[`IRQC_PULSE_HI:`IRQC_PULSE_LO];
    wire fw_write = fw_sel & fw_wr & clk_en;
    wire fw_read = fw_sel & fw_rd & clk_en;
    wire host_write = host_sel & host_wr & clk_en;
    wire host_read = host_sel & host_rd & clk_en;
    wire fw_out_wr = fw_write & ~fw_ctl_sel &
        ((fw_addr == `REG_KEYBOARD_DATA_OUT) | (fw_addr == `REG_MOUSE_DATA_OUT) |
         (fw_addr == `REG_PM_DATA_OUT));
    wire fifo_in_ok = fw_out_wr & (fifo_count != 2'd2);
    wire [9:0] fifo_head = fifo_data[fifo_rd_ptr];
    wire head_pm = (fifo_head[9:8] == 2'd2);
    // Drain only into an empty buffer so a byte the host has not read is never lost
    wire fifo_out_ok = (fifo_count != 2'd0) & clk_en &
        (head_pm ? ~pm_channel_status[`ST_OUTBUF_FULL]
                 : ~kbc_channel_status[`ST_OUTBUF_FULL]);
    wire kbc_load = fifo_out_ok & ~head_pm;
    wire pm_load = fifo_out_ok & head_pm;
    wire [2:0] load_line = {pm_load, kbc_load & fifo_head[8], kbc_load & ~fifo_head[8]};
    wire [2:0] hw_en = {host_iface_control[`HIC_PM_HOST_IRQ_EN],
        host_iface_control[`HIC_MOUSE_HOST_IRQ_EN], host_iface_control[`HIC_KBD_HOST_IRQ_EN]};

    assign fw_out_ready = (fifo_count != 2'd2);

    function [4:0] pulse_len;
        input [2:0] m;
        begin
            case (m)
                3'h1: pulse_len = `PULSE_CYCLES_1;
                3'h2: pulse_len = `PULSE_CYCLES_2;
                3'h3: pulse_len = `PULSE_CYCLES_4;
                3'h4: pulse_len = `PULSE_CYCLES_8;
                3'h5: pulse_len = `PULSE_MAX_CYCLES;
                // Reserved codes behave as the longest pulse
                default: pulse_len = `PULSE_MAX_CYCLES;
            endcase
        end
    endfunction

    function [4:0] next_count;
        input load;
        input [4:0] cnt;
        input [2:0] m;
        begin
            if (load)
                next_count = pulse_len(m);
            else if (cnt != 5'd0)
                next_count = cnt - 5'd1;
            else
                next_count = 5'd0;
        end
    endfunction

    function in_port_hit;
        input [7:0] a;
        input [7:0] data_port;
        input [7:0] cmd_port;
        begin
            in_port_hit = (a == data_port) | (a == cmd_port);
        end
    endfunction

    // Host writes, host data-port reads and firmware reads that move the full flags
    wire kbc_in_wr = host_write & in_port_hit(host_addr, `HOST_KBC_DATA, `HOST_KBC_CMD);
    wire pm_in_wr = host_write & in_port_hit(host_addr, `HOST_PM_DATA, `HOST_PM_CMD);
    wire kbc_out_rd = host_read & (host_addr == `HOST_KBC_DATA);
    wire pm_out_rd = host_read & (host_addr == `HOST_PM_DATA);
    wire kbc_in_rd = fw_read & ~fw_ctl_sel & (fw_addr == `REG_KBC_DATA_IN);
    wire pm_in_rd = fw_read & ~fw_ctl_sel & (fw_addr == `REG_PM_DATA_IN);

    always @(posedge clk)
    begin
        if (!nrst)
        begin
            // Released lines idle high behind their pull-ups
            pin_s1 <= 3'h7;
            pin_s2 <= 3'h7;
            pin_s3 <= 3'h7;
            pin_level <= 3'h7;
        end
        else if (clk_en)
        begin
            pin_s1 <= irq_pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            for (i = 0; i < 3; i = i + 1)
                if (pin_s2[i] == pin_s3[i])
                    pin_level[i] <= pin_s3[i];
        end
    end

    always @(posedge clk)
    begin
        if (!nrst)
        begin
            irq_line_control <= `IRQ_LINE_CONTROL_RESET;
            host_iface_control <= `HOST_IFACE_CONTROL_RESET;
            kbc_channel_status <= `STATUS_RESET;
            pm_channel_status <= `STATUS_RESET;
            kbc_in_buffer <= 8'h00;
            pm_in_buffer <= 8'h00;
            kbc_out_buffer <= 8'h00;
            pm_out_buffer <= 8'h00;
        end
        else if (clk_en)
        begin
            if (fw_write & fw_ctl_sel)
                host_iface_control <= {1'b0, fw_wdata[6:0]};
            if (fw_write & ~fw_ctl_sel)
            begin
                if (fw_addr == `REG_IRQ_LINE_CONTROL)
                    irq_line_control <= fw_wdata;
                else if (fw_addr == `REG_KBC_CHANNEL_STATUS)
                    kbc_channel_status <= (kbc_channel_status & ~`ST_FW_WRITE_MASK) |
                        (fw_wdata & `ST_FW_WRITE_MASK);
                else if (fw_addr == `REG_PM_CHANNEL_STATUS)
                    pm_channel_status <= (pm_channel_status & ~`ST_FW_WRITE_MASK) |
                        (fw_wdata & `ST_FW_WRITE_MASK);
            end

            // Keyboard channel output full: set wins over a host read in the same cycle
            if (kbc_load)
            begin
                kbc_out_buffer <= fifo_head[7:0];
                kbc_channel_status[`ST_OUTBUF_FULL] <= 1'b1;
            end
            else if (kbc_out_rd)
                kbc_channel_status[`ST_OUTBUF_FULL] <= 1'b0;
            if (pm_load)
            begin
                pm_out_buffer <= fifo_head[7:0];
                pm_channel_status[`ST_OUTBUF_FULL] <= 1'b1;
            end
            else if (pm_out_rd)
                pm_channel_status[`ST_OUTBUF_FULL] <= 1'b0;

            if (kbc_in_wr)
            begin
                kbc_in_buffer <= host_wdata;
                kbc_channel_status[`ST_INBUF_FULL] <= 1'b1;
                kbc_channel_status[`ST_LAST_CMD_ADDR] <= host_addr[2];
            end
            else if (kbc_in_rd)
                kbc_channel_status[`ST_INBUF_FULL] <= 1'b0;
            if (pm_in_wr)
            begin
                pm_in_buffer <= host_wdata;
                pm_channel_status[`ST_INBUF_FULL] <= 1'b1;
                pm_channel_status[`ST_LAST_CMD_ADDR] <= host_addr[2];
            end
            else if (pm_in_rd)
                pm_channel_status[`ST_INBUF_FULL] <= 1'b0;
        end
    end

    // Two entries let firmware run two bytes ahead of a slow host; a write while both are full is dropped
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            fifo_rd_ptr <= 1'b0;
            fifo_wr_ptr <= 1'b0;
            fifo_count <= 2'd0;
        end
        else if (clk_en)
        begin
            if (fifo_in_ok)
            begin
                fifo_data[fifo_wr_ptr] <= {(fw_addr == `REG_PM_DATA_OUT) ? 2'd2 :
                    (fw_addr == `REG_MOUSE_DATA_OUT) ? 2'd1 : 2'd0, fw_wdata};
                fifo_wr_ptr <= ~fifo_wr_ptr;
            end
            if (fifo_out_ok)
                fifo_rd_ptr <= ~fifo_rd_ptr;
            if (fifo_in_ok & ~fifo_out_ok)
                fifo_count <= fifo_count + 2'd1;
            else if (fifo_out_ok & ~fifo_in_ok)
                fifo_count <= fifo_count - 2'd1;
        end
    end

    // Length is fixed at load, so a mode change cannot stretch a pulse in flight
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            pulse_cnt0 <= 5'd0;
            pulse_cnt1 <= 5'd0;
            pulse_cnt2 <= 5'd0;
        end
        else if (clk_en)
        begin
            pulse_cnt0 <= next_count(load_line[0], pulse_cnt0, mode);
            pulse_cnt1 <= next_count(load_line[1], pulse_cnt1, mode);
            pulse_cnt2 <= next_count(load_line[2], pulse_cnt2, mode);
        end
    end

    always @*
    begin
        pulse_active = {pulse_cnt2 != 5'd0, pulse_cnt1 != 5'd0, pulse_cnt0 != 5'd0};
        if (mode == 3'h0)
            hw_line = {pm_channel_status[`ST_OUTBUF_FULL],
                kbc_channel_status[`ST_OUTBUF_FULL] & fifo_last_mouse,
                kbc_channel_status[`ST_OUTBUF_FULL] & ~fifo_last_mouse};
        else
            hw_line = ~pulse_active;
        for (j = 0; j < 3; j = j + 1)
        begin
            if (hw_en[j])
                line_value[j] = hw_line[j] ^ irq_line_control[`IRQC_INVERT];
            else
                line_value[j] = irq_line_control[j];
        end
    end

    always @(posedge clk)
    begin
        if (!nrst)
            fifo_last_mouse <= 1'b0;
        else if (clk_en)
        begin
            if (kbc_load)
                fifo_last_mouse <= fifo_head[8];
        end
    end

    always @(posedge clk)
    begin
        if (!nrst)
        begin
            irq_out <= 3'h0;
            irq_oe_n <= 3'h7;
        end
        else if (clk_en)
        begin
            irq_out <= line_value;
            if (irq_line_control[`IRQC_PUSH_PULL])
                irq_oe_n <= 3'h0;
            else
                irq_oe_n <= line_value;
        end
    end

    assign kbc_core_empty_irq = host_iface_control[`HIC_KBC_CORE_EMPTY_EN] &
        ~kbc_channel_status[`ST_OUTBUF_FULL];
    assign kbc_core_full_irq = host_iface_control[`HIC_KBC_CORE_FULL_EN] &
        kbc_channel_status[`ST_INBUF_FULL];
    assign pm_core_empty_irq = host_iface_control[`HIC_PM_CORE_EMPTY_EN] &
        ~pm_channel_status[`ST_OUTBUF_FULL];
    assign pm_core_full_irq = host_iface_control[`HIC_PM_CORE_FULL_EN] &
        pm_channel_status[`ST_INBUF_FULL];

    always @(posedge clk)
    begin
        if (!nrst)
        begin
            host_rdata <= 8'h00;
            fw_rdata <= 8'h00;
        end
        else if (clk_en)
        begin
            if (host_addr == `HOST_KBC_CMD)
                host_rdata <= kbc_channel_status;
            else if (host_addr == `HOST_PM_CMD)
                host_rdata <= pm_channel_status;
            else if (host_addr == `HOST_KBC_DATA)
                host_rdata <= kbc_out_buffer;
            else if (host_addr == `HOST_PM_DATA)
                host_rdata <= pm_out_buffer;
            else
                host_rdata <= 8'h00;
            if (fw_ctl_sel)
                fw_rdata <= host_iface_control;
            else if (fw_addr == `REG_IRQ_LINE_CONTROL)
                fw_rdata <= {irq_line_control[7:3], pin_level};
            else if (fw_addr == `REG_KBC_CHANNEL_STATUS)
                fw_rdata <= kbc_channel_status;
            else if (fw_addr == `REG_PM_CHANNEL_STATUS)
                fw_rdata <= pm_channel_status;
            else if (fw_addr == `REG_KBC_DATA_IN)
                fw_rdata <= kbc_in_buffer;
            else if (fw_addr == `REG_PM_DATA_IN)
                fw_rdata <= pm_in_buffer;
            else
                fw_rdata <= 8'h00;
        end
    end

endmodule // kbc_pm_host_mailbox

// ### kbc_pm_host_mailbox_assertions.sv
`timescale 1ns/1ps
module kbc_pm_host_mailbox_checker
(
    input wire clk,
    input wire nrst,
    input wire clk_en,
    input wire host_sel,
    input wire host_wr,
    input wire host_rd,
    input wire [7:0] host_addr,
    input wire fw_sel,
    input wire fw_wr,
    input wire fw_rd,
    input wire fw_ctl_sel,
    input wire [2:0] fw_addr,
    input wire fw_out_ready,
    input wire [2:0] irq_out,
    input wire [2:0] irq_oe_n,
    input wire kbc_core_empty_irq,
    input wire kbc_core_full_irq,
    input wire pm_core_empty_irq,
    input wire pm_core_full_irq
);
    wire hw = host_sel && host_wr && clk_en;
    wire fw = fw_sel && fw_wr && clk_en && !fw_ctl_sel;
    wire fr = fw_sel && fw_rd && clk_en && !fw_ctl_sel;
    wire cw = fw_sel && fw_wr && clk_en && fw_ctl_sel;
    wire k_in = hw && (host_addr & 8'hfb) == 8'h60;
    wire pm_in = hw && (host_addr & 8'hfb) == 8'h62;
    wire k_rd = fr && fw_addr == 3'h4;
    wire pm_rd = fr && fw_addr == 3'h7;
    // Queued entries of the other channel could otherwise delay the load
    wire calm = fw_out_ready && kbc_core_empty_irq && pm_core_empty_irq;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    property p_rel; $rose(nrst) |-> irq_oe_n == 3'h7; endproperty
    a_rel: assert property (p_rel) else $error("lines driven after reset");
    property p_od; $past(nrst) |-> (irq_oe_n & ~irq_out) == 3'h0; endproperty
    a_od: assert property (p_od) else $error("line released while low");
    property p_kdrop; fw && fw_addr[2:1] == 2'b01 && calm |-> ##2 !kbc_core_empty_irq; endproperty
    a_kdrop: assert property (p_kdrop) else $error("kbc empty irq kept");
    property p_pdrop; fw && fw_addr == 3'h6 && calm |-> ##2 !pm_core_empty_irq; endproperty
    a_pdrop: assert property (p_pdrop) else $error("pm empty irq kept");
    property p_kset; $rose(kbc_core_full_irq) |-> $past(k_in) || $past(cw); endproperty
    a_kset: assert property (p_kset) else $error("kbc full irq without write");
    property p_kclr; $fell(kbc_core_full_irq) |-> $past(k_rd) || $past(cw); endproperty
    a_kclr: assert property (p_kclr) else $error("kbc full irq without read");
    property p_pset; $rose(pm_core_full_irq) |-> $past(pm_in) || $past(cw); endproperty
    a_pset: assert property (p_pset) else $error("pm full irq without write");
    property p_pclr; $fell(pm_core_full_irq) |-> $past(pm_rd) || $past(cw); endproperty
    a_pclr: assert property (p_pclr) else $error("pm full irq without read");
    c_pulse: cover property ($fell(irq_out[0]));
    c_stall: cover property (!fw_out_ready);
    c_cmd: cover property (k_in && host_addr[2]);
endmodule // kbc_pm_host_mailbox_checker

bind kbc_pm_host_mailbox kbc_pm_host_mailbox_checker checker_i (.clk, .nrst, .clk_en,
    .host_sel, .host_wr, .host_rd, .host_addr, .fw_sel, .fw_wr, .fw_rd, .fw_ctl_sel,
    .fw_addr, .fw_out_ready, .irq_out, .irq_oe_n, .kbc_core_empty_irq,
    .kbc_core_full_irq, .pm_core_empty_irq, .pm_core_full_irq);

// ### host_io_model.sv
`timescale 1ns/1ps
module host_io_model
(
    input wire clk,
    output logic host_sel,
    output logic host_wr,
    output logic host_rd,
    output logic [7:0] host_addr,
    output logic [7:0] host_wdata,
    input wire [7:0] host_rdata,
    input wire [2:0] irq_out,
    input wire [2:0] irq_oe_n,
    output wire [2:0] irq_pin
);
    // Board pull-ups take released lines high
    assign irq_pin = irq_out | irq_oe_n;
    initial
    begin
        host_sel = 1'b0;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_addr = 8'h00;
        host_wdata = 8'h00;
    end
    // Idle bus shows inverted leftovers, never stale values
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        host_sel = 1'b1;
        host_wr = w;
        host_rd = !w;
        host_addr = a;
        host_wdata = d;
        @(negedge clk);
        host_sel = 1'b0;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_addr = ~a;
        host_wdata = ~d;
    endtask
endmodule // host_io_model

// ### kbc_pm_host_mailbox_bench.sv
`timescale 1ns/1ps
module kbc_pm_host_mailbox_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic fw_sel = 1'b0;
    logic fw_wr = 1'b0;
    logic fw_rd = 1'b0;
    logic fw_ctl_sel = 1'b0;
    logic [2:0] fw_addr = 3'h0;
    logic [7:0] fw_wdata = 8'h00;
    logic [7:0] fq;
    wire host_sel, host_wr, host_rd, fw_out_ready;
    wire [7:0] host_addr, host_wdata, host_rdata, fw_rdata;
    wire [2:0] irq_out, irq_oe_n, irq_pin;
    wire kbc_core_empty_irq, kbc_core_full_irq, pm_core_empty_irq, pm_core_full_irq;
    int bad_count = 0;
    int compares = 0;
    always #25 clk = ~clk;
    kbc_pm_host_mailbox dut (.clk, .nrst, .clk_en, .host_sel, .host_wr, .host_rd,
        .host_addr, .host_wdata, .host_rdata, .fw_sel, .fw_wr, .fw_rd, .fw_ctl_sel, .fw_addr,
        .fw_wdata, .fw_rdata, .fw_out_ready, .irq_pin_in(irq_pin), .irq_out, .irq_oe_n,
        .kbc_core_empty_irq, .kbc_core_full_irq, .pm_core_empty_irq, .pm_core_full_irq);
    host_io_model pc (.clk, .host_sel, .host_wr, .host_rd, .host_addr, .host_wdata,
        .host_rdata, .irq_out, .irq_oe_n, .irq_pin);
    task automatic give_verdict;
        $display("Checks %0d, errors %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic fwa(input logic c, w, input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        fw_sel = 1'b1;
        fw_wr = w;
        fw_rd = !w;
        fw_ctl_sel = c;
        fw_addr = a;
        fw_wdata = d;
        @(negedge clk);
        fw_sel = 1'b0;
        fw_wr = 1'b0;
        fw_rd = 1'b0;
        fw_wdata = ~d;
        fq = fw_rdata;
    endtask
    task automatic s_reset;
        repeat (5) @(negedge clk);
        fwa(0, 0, 3'h0, 8'h00);
        chk("line_ctl", 8'h07, fq);
        chk("pins", 8'h07, 8'(irq_pin));
        pc.acc(0, 8'h64, 8'h00);
        chk("kbc_st", 8'h00, host_rdata);
        pc.acc(0, 8'h66, 8'h00);
        chk("pm_st", 8'h00, host_rdata);
    endtask
    task automatic s_direct;
        fwa(0, 1, 3'h0, 8'h02);
        repeat (5) @(negedge clk);
        fwa(0, 0, 3'h0, 8'h00);
        chk("direct", 8'h02, fq);
        chk("od_pins", 8'h02, 8'(irq_pin));
        fwa(0, 1, 3'h0, 8'h85);
        repeat (5) @(negedge clk);
        fwa(0, 0, 3'h0, 8'h00);
        chk("direct_pp", 8'h85, fq);
        chk("pp_oe", 8'h00, 8'(irq_oe_n));
    endtask
    task automatic s_chan(input logic [7:0] da, input logic [2:0] din, dout, input int k);
        fwa(1, 1, 3'h0, 8'h7f);
        fwa(0, 1, 3'h0, 8'h00);
        repeat (3) @(negedge clk);
        chk("lvl_idle", 8'h00, 8'(irq_pin[k]));
        chk("empty_irq", 8'h01, 8'(k ? pm_core_empty_irq : kbc_core_empty_irq));
        pc.acc(1, da + 8'h04, 8'h5a);
        pc.acc(0, da + 8'h04, 8'h00);
        chk("st_cmd", 8'h0a, host_rdata);
        chk("full_irq", 8'h01, 8'(k ? pm_core_full_irq : kbc_core_full_irq));
        fwa(0, 0, din, 8'h00);
        chk("data_in", 8'h5a, fq);
        pc.acc(1, da, 8'h11);
        pc.acc(0, da + 8'h04, 8'h00);
        chk("st_data", 8'h02, host_rdata);
        fwa(0, 0, din, 8'h00);
        chk("data_in2", 8'h11, fq);
        chk("full_off", 8'h00, 8'(k ? pm_core_full_irq : kbc_core_full_irq));
        fwa(0, 1, dout, 8'hc3);
        repeat (3) @(negedge clk);
        chk("lvl_high", 8'h01, 8'(irq_pin[k]));
        chk("empty_off", 8'h00, 8'(k ? pm_core_empty_irq : kbc_core_empty_irq));
        pc.acc(0, da + 8'h04, 8'h00);
        chk("st_out", 8'h01, host_rdata);
        pc.acc(0, da, 8'h00);
        chk("data_out", 8'hc3, host_rdata);
        pc.acc(0, da + 8'h04, 8'h00);
        chk("st_clr", 8'h00, host_rdata);
    endtask
    task automatic s_pulse;
        int n;
        int w;
        for (int m = 1; m < 8; m++)
        begin
            fwa(0, 1, 3'h0, 8'(m << 3) | 8'h07);
            repeat (3) @(negedge clk);
            chk("p_idle", 8'h01, 8'(irq_pin[0]));
            fwa(0, 1, 3'h2, 8'(m));
            n = 0;
            w = 0;
            while (irq_pin[0] && w < 8)
            begin
                @(negedge clk);
                w++;
            end
            while (!irq_pin[0] && n < 40)
            begin
                @(negedge clk);
                n++;
            end
            if (w == 8 || n == 40)
            begin
                $display("Error p_wait expected pulse seen timeout");
                bad_count++;
                give_verdict;
            end
            chk("p_width", m > 5 ? 8'h10 : 8'(1 << (m - 1)), 8'(n));
            pc.acc(0, 8'h60, 8'h00);
            chk("p_data", 8'(m), host_rdata);
        end
        fwa(0, 1, 3'h0, 8'hc7);
        repeat (3) @(negedge clk);
        chk("inv_idle", 8'h01, 8'(irq_pin[0]));
        fwa(0, 1, 3'h2, 8'h99);
        repeat (3) @(negedge clk);
        chk("inv_act", 8'h00, 8'(irq_pin[0]));
        pc.acc(0, 8'h60, 8'h00);
    endtask
    // Host stalls while the two-entry buffer fills and refuses
    task automatic s_buf;
        fwa(0, 1, 3'h0, 8'h00);
        fwa(0, 1, 3'h3, 8'hb1);
        repeat (3) @(negedge clk);
        chk("mouse_pin", 8'h02, 8'(irq_pin[1:0]));
        for (int i = 2; i < 5; i++)
            fwa(0, 1, 3'h2, 8'(8'hb0 + i));
        chk("ready", 8'h00, 8'(fw_out_ready));
        for (int i = 1; i < 4; i++)
        begin
            pc.acc(0, 8'h60, 8'h00);
            chk("drain", 8'(8'hb0 + i), host_rdata);
            repeat (3) @(negedge clk);
        end
        pc.acc(0, 8'h64, 8'h00);
        chk("drained", 8'h00, host_rdata);
    endtask
    task automatic s_status;
        for (int i = 0; i < 2; i++)
        begin
            fwa(0, 1, i ? 3'h5 : 3'h1, 8'hff);
            fwa(0, 0, i ? 3'h5 : 3'h1, 8'h00);
            chk("fw_st", 8'hf4, fq);
            pc.acc(0, i ? 8'h66 : 8'h64, 8'h00);
            chk("host_st", 8'hf4, host_rdata);
        end
    endtask
    // Clock enable low: neither side may move a flag
    task automatic s_freeze;
        clk_en = 1'b0;
        fwa(0, 1, 3'h6, 8'h3c);
        pc.acc(1, 8'h62, 8'h44);
        clk_en = 1'b1;
        pc.acc(0, 8'h66, 8'h00);
        chk("frozen_st", 8'hf4, host_rdata);
        chk("frozen_irq", 8'h00, 8'(pm_core_full_irq));
    endtask
    initial
    begin
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        s_reset;
        s_direct;
        s_chan(8'h60, 3'h4, 3'h2, 0);
        s_chan(8'h62, 3'h7, 3'h6, 2);
        s_pulse;
        s_buf;
        s_status;
        s_freeze;
        give_verdict;
    end
endmodule // kbc_pm_host_mailbox_bench
